// [src/mtc_chart_io.sv]
// Chart output engine, rear-panel trigger handshake and remote interface settings.
// Assumes an AHB-Lite master on hclk, readings from the measurement core and an
// external non-volatile store that restores and saves the settings image.
`timescale 1ns/1ps
`default_nettype none
`include "mtc_map.svh"

// How it works
// (R1) Low pulse on each finished measurement; all readings during one pulse share a single next pulse
// (R2) External trigger starts measurement only if selected
// (R3) Chart value is (reading minus offset) over span
// (R4) Chart value stays within minus/plus three volts
// (R5) Chart disabled commands zero volts
// (R6) Negative span writes are refused
// (R7) Chart enable, span, offset are non-volatile
// (R8) Overrange wraps to opposite limit
// (R9) Chart null loads displayed reading into offset
// (R10) Exactly one interface, GPIB by default
// (R11) I/O settings survive power loss, remote reset
// (R12) Interface and address set only locally
// (R13) Address zero to thirty-one, default twenty-two
// (R14) Address thirty-one means talk-only
// (R15) Serial talk-only sends readings in local
// (R16) Six baud rates, default 9600
// (R17) No parity eight bits, else seven
// (R18) Default even parity, seven bits
// (R19) SCPI default; legacy refused on serial
// (R20) Power-up shows address or serial name
// (R21) Trigger synchronised, one per falling edge
module mtc_chart_io (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic [31:0] hrdata,
	output logic hresp,
	input wire logic reading_valid,
	input wire logic [31:0] reading,
	input wire logic ext_trig_n,
	output logic meas_trigger,
	output logic measurement_done_pulse_n,
	output logic signed [15:0] chart_mv,
	input wire logic panel_local,
	input wire logic local_mode,
	input wire logic remote_reset,
	input wire logic nv_restore_valid,
	input wire mtc_pkg::mtc_nv_t nv_restore,
	output mtc_pkg::mtc_nv_t nv_image,
	output logic nv_commit,
	output logic gpib_en,
	output logic rs232_en,
	output logic talk_only,
	output logic serial_talk_tx,
	output logic [3:0] data_bits,
	output mtc_pkg::mtc_banner_t banner
);
	import mtc_pkg::*;

	localparam int unsigned DONE_CYC = (`MTC_DONE_PULSE_NS * `MTC_CLK_MHZ + 999) / 1000;
	localparam int unsigned DCNT_W = $clog2(DONE_CYC + 1);
	localparam int unsigned NUM_W = 44;
	localparam int unsigned QW = 46;
	localparam logic [QW-1:0] LIM = QW'(`MTC_CHART_LIM_MV);
	localparam logic [QW-1:0] WRAP_W = QW'(2 * `MTC_CHART_LIM_MV + 1);

	// Bus state
	logic wr_pend_reg, wr_pend_next;
	logic [7:0] wr_addr_reg, wr_addr_next;
	logic [31:0] hrdata_reg, hrdata_next;
	logic accept, wr_en;
	logic [31:0] rd_mux;

	// Settings state
	mtc_nv_t nv_reg, nv_next;
	logic trig_ext_reg, trig_ext_next;
	logic span_rej_reg, span_rej_next;
	logic commit_reg, commit_next;
	logic gpib_reg, gpib_next;
	logic rs_reg, rs_next;
	logic talk_reg, talk_next;
	logic stx_reg, stx_next;
	logic [3:0] bits_reg, bits_next;
	logic boot_reg, boot_next;
	logic rest_dly_reg, rest_dly_next;
	mtc_banner_t banner_reg, banner_next;

	// Chart engine state
	mtc_state_t state_reg, state_next;
	logic [NUM_W-1:0] num_reg, num_next;
	logic [NUM_W-1:0] quot_reg, quot_next;
	logic [32:0] rem_reg, rem_next;
	logic [5:0] cnt_reg, cnt_next;
	logic neg_reg, neg_next;
	logic [15:0] calc_reg, calc_next;
	logic [15:0] chart_reg, chart_next;
	logic [31:0] last_rd_reg, last_rd_next;

	// Handshake state
	logic s1_reg, s2_reg, s3_reg;
	logic trig_reg, trig_next;
	logic [DCNT_W-1:0] dcnt_reg, dcnt_next;
	logic dpend_reg, dpend_next;
	logic done_n_reg, done_n_next;

	// Read mux, decoded in the address phase so data is ready in the data phase
	always_comb begin
		rd_mux = 32'h0;
		if (haddr[31:8] == 24'h0) begin
			unique case (haddr[7:0])
				`MTC_OFF_CTRL: begin
					rd_mux[`MTC_CTRL_CHART_EN] = nv_reg.chart_en;
					rd_mux[`MTC_CTRL_TRIG_EXT] = trig_ext_reg;
				end
				`MTC_OFF_SPAN: rd_mux = nv_reg.span;
				`MTC_OFF_OFFSET: rd_mux = nv_reg.offset;
				`MTC_OFF_IOCFG: begin
					rd_mux[`MTC_IO_IFACE] = nv_reg.iface;
					rd_mux[`MTC_IO_ADDR_MSB:`MTC_IO_ADDR_LSB] = nv_reg.addr;
					rd_mux[`MTC_IO_BAUD_MSB:`MTC_IO_BAUD_LSB] = nv_reg.baud;
					rd_mux[`MTC_IO_PAR_MSB:`MTC_IO_PAR_LSB] = nv_reg.parity;
					rd_mux[`MTC_IO_LANG] = nv_reg.lang;
				end
				`MTC_OFF_STATUS: begin
					rd_mux[`MTC_ST_VAL_MSB:0] = chart_reg;
					rd_mux[`MTC_ST_BUSY] = (state_reg != MTC_ST_IDLE);
					rd_mux[`MTC_ST_SPAN_REJ] = span_rej_reg;
					rd_mux[`MTC_ST_TALK_ONLY] = talk_reg;
				end
				`MTC_OFF_READING: rd_mux = last_rd_reg;
				default: rd_mux = 32'h0;
			endcase
		end
	end

	// Bus slave: zero wait states, writes land in the data phase
	always_comb begin
		accept = hsel & hready & htrans[1];
		wr_pend_next = accept & hwrite;
		wr_addr_next = accept ? haddr[7:0] : wr_addr_reg;
		if (accept && (haddr[31:8] != 24'h0)) begin
			wr_addr_next = 8'hff; // Unmapped: writes dropped
		end
		hrdata_next = (accept & ~hwrite) ? rd_mux : hrdata_reg;
		wr_en = wr_pend_reg;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_reg <= 1'b0;
			wr_addr_reg <= 8'h0;
			hrdata_reg <= 32'h0;
			hreadyout <= 1'b0;
		end else begin
			wr_pend_reg <= wr_pend_next;
			wr_addr_reg <= wr_addr_next;
			hrdata_reg <= hrdata_next;
			hreadyout <= 1'b1;
		end
	end

	// Settings update; remote reset touches only volatile trigger source
	always_comb begin
		nv_next = nv_reg;
		trig_ext_next = trig_ext_reg;
		span_rej_next = span_rej_reg;
		if (nv_restore_valid) begin
			nv_next = nv_restore; // R7 R11
		end else if (wr_en) begin
			unique case (wr_addr_reg)
				`MTC_OFF_CTRL: begin
					nv_next.chart_en = hwdata[`MTC_CTRL_CHART_EN];
					trig_ext_next = hwdata[`MTC_CTRL_TRIG_EXT];
					if (hwdata[`MTC_CTRL_CHART_NULL]) begin
						nv_next.offset = last_rd_reg; // R9
					end
				end
				`MTC_OFF_SPAN: begin
					if (hwdata[`MTC_SPAN_SIGN]) begin
						span_rej_next = 1'b1; // R6
					end else begin
						nv_next.span = hwdata;
					end
				end
				`MTC_OFF_OFFSET: nv_next.offset = hwdata;
				`MTC_OFF_IOCFG: begin
					if (panel_local) begin // R12
						nv_next.iface = mtc_iface_t'(hwdata[`MTC_IO_IFACE]); // R10
						nv_next.addr = hwdata[`MTC_IO_ADDR_MSB:`MTC_IO_ADDR_LSB]; // R13
					end
					if (hwdata[`MTC_IO_BAUD_MSB:`MTC_IO_BAUD_LSB] <= `MTC_BAUD_MAX) begin
						nv_next.baud = mtc_baud_t'(hwdata[`MTC_IO_BAUD_MSB:`MTC_IO_BAUD_LSB]); // R16
					end
					if (hwdata[`MTC_IO_PAR_MSB:`MTC_IO_PAR_LSB] != `MTC_PAR_ILLEGAL) begin
						nv_next.parity = mtc_parity_t'(hwdata[`MTC_IO_PAR_MSB:`MTC_IO_PAR_LSB]);
					end
					nv_next.lang = mtc_lang_t'(hwdata[`MTC_IO_LANG]);
				end
				`MTC_OFF_STATUS: begin
					if (hwdata[`MTC_ST_SPAN_REJ]) begin
						span_rej_next = 1'b0;
					end
				end
				default: nv_next = nv_reg;
			endcase
		end
		// Legacy language never coexists with the serial port
		if (nv_next.iface == MTC_IF_RS232) begin
			nv_next.lang = MTC_LANG_SCPI; // R19
		end
		if (remote_reset) begin
			trig_ext_next = 1'b0; // R11
		end
		commit_next = !nv_restore_valid && (nv_next != nv_reg);
		gpib_next = (nv_next.iface == MTC_IF_GPIB); // R10
		rs_next = (nv_next.iface == MTC_IF_RS232);
		talk_next = (nv_next.addr == `MTC_ADDR_TALK); // R14
		stx_next = rs_next & talk_next & local_mode; // R15
		bits_next = (nv_next.parity == MTC_PAR_NONE) ? `MTC_BITS_NOPAR : `MTC_BITS_PAR; // R17
		boot_next = 1'b0;
		rest_dly_next = nv_restore_valid;
		banner_next.show = boot_reg | rest_dly_reg; // R20
		banner_next.is_serial = (nv_reg.iface == MTC_IF_RS232);
		banner_next.addr = nv_reg.addr;
	end

	// Factory image at reset (R10 R13 R16 R18 R19); the store restores after release
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			nv_reg <= MTC_NV_FACTORY;
			trig_ext_reg <= 1'b0;
			span_rej_reg <= 1'b0;
			commit_reg <= 1'b0;
			gpib_reg <= 1'b1;
			rs_reg <= 1'b0;
			talk_reg <= 1'b0;
			stx_reg <= 1'b0;
			bits_reg <= `MTC_BITS_PAR;
			boot_reg <= 1'b1;
			rest_dly_reg <= 1'b0;
			banner_reg <= '0;
		end else begin
			nv_reg <= nv_next;
			trig_ext_reg <= trig_ext_next;
			span_rej_reg <= span_rej_next;
			commit_reg <= commit_next;
			gpib_reg <= gpib_next;
			rs_reg <= rs_next;
			talk_reg <= talk_next;
			stx_reg <= stx_next;
			bits_reg <= bits_next;
			boot_reg <= boot_next;
			rest_dly_reg <= rest_dly_next;
			banner_reg <= banner_next;
		end
	end

	// Chart engine: serial divide, then wrap into the output window
	// Serial divide trades 44 cycles of latency for one subtractor
	always_comb begin
		logic [32:0] diff;
		logic [32:0] mag;
		logic [32:0] rsh;
		logic [QW-1:0] qs, t, tu, m, r, v;
		diff = 33'h0;
		mag = 33'h0;
		rsh = 33'h0;
		qs = '0;
		t = '0;
		tu = '0;
		m = '0;
		r = '0;
		v = '0;
		state_next = state_reg;
		num_next = num_reg;
		quot_next = quot_reg;
		rem_next = rem_reg;
		cnt_next = cnt_reg;
		neg_next = neg_reg;
		calc_next = calc_reg;
		last_rd_next = reading_valid ? reading : last_rd_reg;
		unique case (state_reg)
			MTC_ST_IDLE: begin
				if (reading_valid) begin
					diff = {reading[31], reading} - {nv_reg.offset[31], nv_reg.offset}; // R3
					neg_next = diff[32];
					mag = diff[32] ? (~diff + 33'h1) : diff;
					num_next = NUM_W'({11'h0, mag} * NUM_W'(`MTC_MV_PER_V));
					rem_next = 33'h0;
					quot_next = '0;
					cnt_next = 6'(NUM_W - 1);
					if (nv_reg.span == 32'h0) begin
						calc_next = 16'h0; // Zero span has no meaning: park at 0 V
					end else begin
						state_next = MTC_ST_DIV;
					end
				end
			end
			MTC_ST_DIV: begin
				rsh = {rem_reg[31:0], num_reg[NUM_W-1]};
				num_next = {num_reg[NUM_W-2:0], 1'b0};
				if (rsh >= {1'b0, nv_reg.span}) begin
					rem_next = rsh - {1'b0, nv_reg.span};
					quot_next = {quot_reg[NUM_W-2:0], 1'b1};
				end else begin
					rem_next = rsh;
					quot_next = {quot_reg[NUM_W-2:0], 1'b0};
				end
				cnt_next = cnt_reg - 6'h1;
				if (cnt_reg == 6'h0) begin
					state_next = MTC_ST_WRAP;
				end
			end
			MTC_ST_WRAP: begin
				qs = neg_reg ? (~{2'b00, quot_reg} + QW'(1)) : {2'b00, quot_reg};
				t = qs + LIM;
				tu = t[QW-1] ? ~t : t;
				m = tu % WRAP_W;
				r = t[QW-1] ? (WRAP_W - QW'(1) - m) : m; // R8
				v = r - LIM; // R4
				calc_next = v[15:0];
				state_next = MTC_ST_IDLE;
			end
			default: state_next = MTC_ST_IDLE;
		endcase
		chart_next = nv_reg.chart_en ? calc_reg : 16'h0; // R5
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_reg <= MTC_ST_IDLE;
			num_reg <= '0;
			quot_reg <= '0;
			rem_reg <= 33'h0;
			cnt_reg <= 6'h0;
			neg_reg <= 1'b0;
			calc_reg <= 16'h0;
			chart_reg <= 16'h0;
			last_rd_reg <= 32'h0;
		end else begin
			state_reg <= state_next;
			num_reg <= num_next;
			quot_reg <= quot_next;
			rem_reg <= rem_next;
			cnt_reg <= cnt_next;
			neg_reg <= neg_next;
			calc_reg <= calc_next;
			chart_reg <= chart_next;
			last_rd_reg <= last_rd_next;
		end
	end

	// Trigger edge and done pulse; one pending done keeps back-to-back readings apart
	always_comb begin
		trig_next = s3_reg & ~s2_reg & trig_ext_reg; // R2 R21
		dcnt_next = dcnt_reg;
		dpend_next = dpend_reg;
		if (dcnt_reg != '0) begin
			dcnt_next = dcnt_reg - DCNT_W'(1);
			dpend_next = dpend_reg | reading_valid;
		end else if ((reading_valid | dpend_reg) & done_n_reg) begin
			dcnt_next = DCNT_W'(DONE_CYC); // R1
			dpend_next = 1'b0;
		end else begin
			dpend_next = dpend_reg | reading_valid;
		end
		done_n_next = (dcnt_next == '0);
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s1_reg <= 1'b1;
			s2_reg <= 1'b1;
			s3_reg <= 1'b1;
			trig_reg <= 1'b0;
			dcnt_reg <= '0;
			dpend_reg <= 1'b0;
			done_n_reg <= 1'b1;
		end else begin
			s1_reg <= ext_trig_n; // R21
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			trig_reg <= trig_next;
			dcnt_reg <= dcnt_next;
			dpend_reg <= dpend_next;
			done_n_reg <= done_n_next;
		end
	end

	// Outputs, all from flip-flops except the tied-off hresp
	assign hrdata = hrdata_reg;
	assign hresp = 1'b0; // Always OKAY
	assign meas_trigger = trig_reg;
	assign measurement_done_pulse_n = done_n_reg;
	assign chart_mv = chart_reg;
	assign nv_image = nv_reg;
	assign nv_commit = commit_reg;
	assign gpib_en = gpib_reg;
	assign rs232_en = rs_reg;
	assign talk_only = talk_reg;
	assign serial_talk_tx = stx_reg;
	assign data_bits = bits_reg;
	assign banner = banner_reg;
endmodule
`default_nettype wire

// [src/mtc_map.svh]
// Register map, field positions, defaults and timing for the chart and I/O config block.
// Assumes inclusion by bare name from the package and the top module.
`ifndef MTC_MAP_SVH
`define MTC_MAP_SVH

// Clock and handshake timing
`define MTC_CLK_MHZ 200
`define MTC_DONE_PULSE_NS 500

// Register byte offsets (low address byte)
`define MTC_OFF_CTRL 8'h00
`define MTC_OFF_SPAN 8'h04
`define MTC_OFF_OFFSET 8'h08
`define MTC_OFF_IOCFG 8'h0c
`define MTC_OFF_STATUS 8'h10
`define MTC_OFF_READING 8'h14

// Control fields
`define MTC_CTRL_CHART_EN 0
`define MTC_CTRL_TRIG_EXT 1
`define MTC_CTRL_CHART_NULL 2

// Interface configuration fields
`define MTC_IO_IFACE 0
`define MTC_IO_ADDR_LSB 1
`define MTC_IO_ADDR_MSB 5
`define MTC_IO_BAUD_LSB 6
`define MTC_IO_BAUD_MSB 8
`define MTC_IO_PAR_LSB 9
`define MTC_IO_PAR_MSB 10
`define MTC_IO_LANG 11

// Status fields
`define MTC_ST_VAL_MSB 15
`define MTC_ST_BUSY 16
`define MTC_ST_SPAN_REJ 17
`define MTC_ST_TALK_ONLY 18

// Values
`define MTC_SPAN_SIGN 31
`define MTC_ADDR_DEF 5'h16
`define MTC_ADDR_TALK 5'h1f
`define MTC_BAUD_MAX 3'h5
`define MTC_PAR_ILLEGAL 2'h3
`define MTC_BITS_NOPAR 4'h8
`define MTC_BITS_PAR 4'h7
`define MTC_CHART_LIM_MV 3000
`define MTC_MV_PER_V 1000

`endif

// [src/mtc_pkg.sv]
// Types shared by the chart and I/O config block.
// Assumes mtc_map.svh is on the include path.
`include "mtc_map.svh"

package mtc_pkg;
	typedef enum logic {MTC_IF_GPIB, MTC_IF_RS232} mtc_iface_t;
	typedef enum logic [1:0] {MTC_PAR_NONE, MTC_PAR_EVEN, MTC_PAR_ODD} mtc_parity_t;
	typedef enum logic {MTC_LANG_SCPI, MTC_LANG_LEGACY} mtc_lang_t;
	typedef enum logic [2:0] {MTC_B300, MTC_B600, MTC_B1200, MTC_B2400, MTC_B4800, MTC_B9600} mtc_baud_t;
	typedef enum logic [1:0] {MTC_ST_IDLE, MTC_ST_DIV, MTC_ST_WRAP} mtc_state_t;

	// Settings kept in non-volatile storage
	typedef struct packed {
		logic chart_en;
		logic [31:0] span;
		logic [31:0] offset;
		mtc_iface_t iface;
		logic [4:0] addr;
		mtc_baud_t baud;
		mtc_parity_t parity;
		mtc_lang_t lang;
	} mtc_nv_t;

	// Power-up banner for the display
	typedef struct packed {
		logic show;
		logic is_serial;
		logic [4:0] addr;
	} mtc_banner_t;

	localparam mtc_nv_t MTC_NV_FACTORY = '{chart_en: 1'b0, span: 32'h0000_0001, offset: 32'h0,
		iface: MTC_IF_GPIB, addr: `MTC_ADDR_DEF, baud: MTC_B9600, parity: MTC_PAR_EVEN,
		lang: MTC_LANG_SCPI};
endpackage

// [verif/mtc_chk.sv]
// Port checker for the chart and I/O config block.
// Assumes it is bound to mtc_chart_io and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module mtc_chk
	import mtc_pkg::*;
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic reading_valid,
	input wire logic ext_trig_n,
	input wire logic meas_trigger,
	input wire logic measurement_done_pulse_n,
	input wire logic signed [15:0] chart_mv,
	input wire logic panel_local,
	input wire logic nv_restore_valid,
	input wire mtc_pkg::mtc_nv_t nv_image,
	input wire logic nv_commit,
	input wire logic gpib_en,
	input wire logic rs232_en,
	input wire logic talk_only,
	input wire logic [3:0] data_bits
);
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	// Low phase of the done pulse, far shorter than its real length
	sequence s_done_low;
		!measurement_done_pulse_n [*8];
	endsequence
	// Trigger pulse needs a falling input three stages back and lasts one cycle
	sequence s_trig;
		$past(ext_trig_n, 4) && !$past(ext_trig_n, 3) ##1 !meas_trigger;
	endsequence
	property p_done; reading_valid && measurement_done_pulse_n |=> s_done_low; endproperty
	property p_trig; meas_trigger |-> s_trig; endproperty
	property p_off; !nv_image.chart_en |=> chart_mv == 16'sh0; endproperty
	property p_lim; chart_mv >= -16'sd3000 && chart_mv <= 16'sd3000; endproperty
	property p_span; !nv_image.span[31]; endproperty
	property p_one; gpib_en != rs232_en && rs232_en == (nv_image.iface == MTC_IF_RS232); endproperty
	property p_talk; talk_only == (nv_image.addr == 5'h1f); endproperty
	property p_bits; data_bits == ((nv_image.parity == MTC_PAR_NONE) ? 4'h8 : 4'h7); endproperty
	property p_lang; nv_image.iface == MTC_IF_RS232 |-> nv_image.lang == MTC_LANG_SCPI; endproperty
	// Remote writes may not move interface or address
	property p_local; !panel_local && !nv_restore_valid |=> $stable({nv_image.iface, nv_image.addr}); endproperty
	// Settings change is announced in the same cycle as the new image, a restore is not
	property p_commit; nv_commit == ($changed(nv_image) && !$past(nv_restore_valid)); endproperty
	a_done: assert property (p_done) else $error("done pulse not low after reading");
	a_trig: assert property (p_trig) else $error("trigger pulse without low input");
	a_off: assert property (p_off) else $error("chart not zero while disabled");
	a_lim: assert property (p_lim) else $error("chart value out of limits");
	a_span: assert property (p_span) else $error("negative span stored");
	a_one: assert property (p_one) else $error("interface enables wrong");
	a_talk: assert property (p_talk) else $error("talk only flag wrong");
	a_bits: assert property (p_bits) else $error("data bits wrong");
	a_lang: assert property (p_lang) else $error("legacy language on serial");
	a_local: assert property (p_local) else $error("interface changed remotely");
	a_commit: assert property (p_commit) else $error("commit pulse wrong");
endmodule

bind mtc_chart_io mtc_chk mtc_chk_inst (.hclk(hclk), .hresetn(hresetn), .reading_valid(reading_valid),
	.ext_trig_n(ext_trig_n), .meas_trigger(meas_trigger), .measurement_done_pulse_n(measurement_done_pulse_n),
	.chart_mv(chart_mv), .panel_local(panel_local), .nv_restore_valid(nv_restore_valid), .nv_image(nv_image),
	.nv_commit(nv_commit),
	.gpib_en(gpib_en), .rs232_en(rs232_en), .talk_only(talk_only), .data_bits(data_bits));
`default_nettype wire

// [verif/mtc_switch_model.sv]
// Switching-equipment stand-in: pulses the trigger line, counts done pulses.
// Assumes a pull-up on the trigger line, so it idles high.
`timescale 1ns/1ps
`default_nettype none
module mtc_switch_model (
	input wire logic hclk,
	input wire logic fire,
	input wire logic [31:0] hold,
	input wire logic measurement_done_pulse_n,
	output logic ext_trig_n,
	output int done_cnt
);
	int left = 0;
	initial ext_trig_n = 1'b1;
	initial done_cnt = 0;
	// Low pulse of hold cycles per request; long holds act as a slow switch
	always @(posedge hclk) begin
		if (fire)
			left <= hold;
		else if (left > 0)
			left <= left - 1;
		ext_trig_n <= !(fire || left > 1);
	end
	// One count per falling edge of the done line
	always @(negedge measurement_done_pulse_n) done_cnt <= done_cnt + 1;
endmodule
`default_nettype wire

// [verif/tb_meter_trigger_chart_io_config.sv]
// Self-checking bench for the chart and I/O config block.
// Assumes the package, the bound checker and the switch model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb_meter_trigger_chart_io_config;
	import mtc_pkg::*;
	logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, rd_pend = 1'b0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, reading = 32'h0, hrdata;
	logic [1:0] htrans = 2'h0;
	logic reading_valid = 1'b0, panel_local = 1'b0, local_mode = 1'b0, remote_reset = 1'b0;
	logic nvr_valid = 1'b0, fire = 1'b0;
	logic hreadyout, hresp, meas_trigger, done_n, nv_commit, gpib_en, rs232_en, talk_only, tx, ext_trig_n;
	logic signed [15:0] chart_mv;
	logic [3:0] data_bits;
	mtc_nv_t nv_image;
	mtc_nv_t nv_restore = MTC_NV_FACTORY;
	mtc_banner_t banner;
	logic [31:0] exp_q[$];
	int num_errors = 0, total_checks = 0, seed = 32'h94c7, hold = 10, done_cnt;

	mtc_chart_io mtc_chart_io_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .reading_valid(reading_valid),
		.reading(reading), .ext_trig_n(ext_trig_n), .meas_trigger(meas_trigger),
		.measurement_done_pulse_n(done_n), .chart_mv(chart_mv), .panel_local(panel_local),
		.local_mode(local_mode), .remote_reset(remote_reset), .nv_restore_valid(nvr_valid),
		.nv_restore(nv_restore), .nv_image(nv_image), .nv_commit(nv_commit), .gpib_en(gpib_en),
		.rs232_en(rs232_en), .talk_only(talk_only), .serial_talk_tx(tx), .data_bits(data_bits),
		.banner(banner));
	mtc_switch_model mtc_switch_model_inst (.hclk(hclk), .fire(fire), .hold(hold),
		.measurement_done_pulse_n(done_n), .ext_trig_n(ext_trig_n), .done_cnt(done_cnt));

	// 200 MHz clock
	always #2.5 hclk = ~hclk;

	task automatic chk(input logic [31:0] got, input logic [31:0] want);
		total_checks++;
		if (got !== want) begin
			num_errors++;
			$display("Error at %0t: got %h, expected %h", $time, got, want);
		end
	endtask

	task automatic results;
		$display("Checks %0d, mismatches %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// Read data is compared only at the edge that ends its data phase
	always @(posedge hclk) begin
		if (rd_pend) begin
			chk(hrdata, exp_q.pop_front());
			chk({31'h0, hresp}, 32'h0); // Always OKAY
		end
		rd_pend <= hsel && htrans[1] && !hwrite && hreadyout;
	end

	// Bounded wait for hready; a stuck slave ends the run
	task automatic ready_edge;
		int n;
		n = 0;
		do begin
			@(posedge hclk);
			n++;
		end while (hreadyout !== 1'b1 && n < 40);
		if (hreadyout !== 1'b1) begin
			num_errors++;
			results;
		end
	endtask

	task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= w;
		ready_edge;
		htrans <= 2'h0;
		hwdata <= d;
		ready_edge;
	endtask

	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask

	task automatic rd(input logic [31:0] a, input logic [31:0] want);
		exp_q.push_back(want);
		bus(1'b0, a, 32'h0);
	endtask

	// One reading; the done line must stay low exactly 100 cycles
	task automatic meas(input logic [31:0] r);
		int low;
		low = 0;
		@(posedge hclk);
		reading <= r;
		reading_valid <= 1'b1;
		@(posedge hclk);
		reading_valid <= 1'b0;
		repeat (250) begin
			@(posedge hclk);
			low += (done_n === 1'b0);
		end
		chk(low, 100);
	endtask

	task automatic trig(input int want);
		int n;
		n = 0;
		@(posedge hclk);
		fire <= 1'b1;
		@(posedge hclk);
		fire <= 1'b0;
		repeat (40) begin
			@(posedge hclk);
			n += (meas_trigger === 1'b1);
		end
		chk(n, want);
	endtask

	task automatic banner_chk(input logic [5:0] want);
		int n;
		n = 0;
		while (banner.show !== 1'b1 && n < 8) begin
			@(posedge hclk);
			n++;
		end
		if (banner.show !== 1'b1) begin
			num_errors++;
			results;
		end
		chk({25'h0, banner.show, banner.is_serial, banner.addr}, {25'h0, 1'b1, want});
	endtask

	// Wrapped chart value in mV, worked out in wide integers
	function automatic logic signed [15:0] chart_exp(input logic signed [31:0] r, input logic signed [31:0] o,
		input logic [31:0] s);
		longint d, q;
		d = longint'(r) - longint'(o);
		q = ((d < 0 ? -d : d) * 1000) / longint'(s);
		if (d < 0)
			q = -q;
		q = (q + 3000) % 6001;
		if (q < 0)
			q += 6001;
		return 16'(q - 3000);
	endfunction

	// Main sequence
	initial begin
		logic [31:0] r;
		logic signed [15:0] e;
		int b, p;
		repeat (20) @(posedge hclk);
		hresetn <= 1'b1;
		banner_chk({1'b0, 5'h16});
		rd(32'h0c, 32'h36c);
		chk({28'h0, data_bits}, 32'h7);
		$display("test defaults done");
		b = 5;
		p = 1;
		for (int i = 0; i < 8; i++) begin
			wr(32'h0c, 32'h83f | i << 6 | (i % 4) << 9);
			if (i < 6)
				b = i;
			if (i % 4 < 3)
				p = i % 4;
			rd(32'h0c, 32'h82c | b << 6 | p << 9);
			chk({28'h0, data_bits}, p == 0 ? 32'h8 : 32'h7);
		end
		panel_local <= 1'b1;
		local_mode <= 1'b1;
		wr(32'h0c, 32'h97f);
		panel_local <= 1'b0;
		rd(32'h0c, 32'h17f);
		chk({28'h0, gpib_en, rs232_en, talk_only, tx}, 32'h7);
		$display("test interface done");
		wr(32'h00, 32'h3);
		trig(1);
		hold = 30;
		trig(1);
		@(posedge hclk);
		remote_reset <= 1'b1;
		@(posedge hclk);
		remote_reset <= 1'b0;
		trig(0);
		rd(32'h00, 32'h1);
		rd(32'h0c, 32'h17f);
		$display("test trigger done");
		wr(32'h04, 32'h8000_0000);
		rd(32'h04, 32'h1);
		rd(32'h10, 32'h6_0000);
		wr(32'h10, 32'h2_0000);
		wr(32'h04, 32'd1000);
		wr(32'h08, 32'd100);
		for (int i = 0; i < 6; i++) begin
			r = $random(seed) % 20000;
			e = chart_exp(r, 32'd100, 32'd1000);
			meas(r);
			chk(32'(chart_mv), 32'(e));
			rd(32'h14, r);
		end
		rd(32'h10, {16'h4, e});
		wr(32'h00, 32'h0);
		repeat (2) @(posedge hclk);
		chk(32'(chart_mv), 32'h0);
		wr(32'h00, 32'h5);
		rd(32'h08, r);
		meas(r);
		chk(32'(chart_mv), 32'h0);
		wr(32'h04, 32'h0);
		meas(r + 32'd1234);
		chk(32'(chart_mv), 32'h0);
		$display("test chart done");
		@(posedge hclk);
		nv_restore.iface <= MTC_IF_RS232;
		nv_restore.addr <= 5'h3;
		nv_restore.span <= 32'd77;
		nvr_valid <= 1'b1;
		@(posedge hclk);
		nvr_valid <= 1'b0;
		banner_chk({1'b1, 5'h3});
		chk(nv_image.span, 32'd77);
		chk({31'h0, rs232_en}, 32'h1);
		wr(32'h104, 32'h0);
		rd(32'h100, 32'h0);
		rd(32'h04, 32'd77);
		chk(done_cnt, 8);
		$display("test restore done");
		repeat (4) @(posedge hclk);
		results;
	end
endmodule
`default_nettype wire
